// >>> core/port8_pkg.sv
/*
  constants shared by the eight-bit io port: register map, reset values,
  pin roles and the bus handshake states.
  assumes a 32-bit avalon-mm byte address bus in front of the port.
*/
package port8_pkg;

  // ==========================================================
  // widths
  localparam int DATA_W = 32;
  localparam int ADDR_W = 18;
  localparam int PORT_W = 8;

  // ==========================================================
  // register map: printed index, byte address is four times it
  localparam logic [15:0] LATCH_IDX = 16'hffdb;
  localparam logic [15:0] DIR_IDX = 16'hffeb;
  localparam logic [ADDR_W-1:0] LATCH_ADDR = {LATCH_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] DIR_ADDR = {DIR_IDX, 2'b00};

  // ==========================================================
  // reset and read-back values
  localparam logic [PORT_W-1:0] LATCH_RST = 8'h00;
  localparam logic [PORT_W-1:0] DIR_RST = 8'h00;
  localparam logic [PORT_W-1:0] DIR_READ = 8'hff;

  // ==========================================================
  // pin roles
  localparam int PIN_GP = 7;
  localparam int PIN_CAP_D = 6;
  localparam int PIN_CAP_C = 5;
  localparam int PIN_CAP_B = 4;
  localparam int PIN_CAP_A = 3;
  localparam int PIN_CMP_B = 2;
  localparam int PIN_CMP_A = 1;
  localparam int PIN_CNT_CLK = 0;

  // ==========================================================
  // bus handshake
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } bus_state_t;

endpackage

// >>> core/bus_handshake.sv
/*
  avalon-mm waitrequest sequencer: every access waits exactly one cycle.
  assumes the master holds read or write until it sees waitrequest low.
*/
module bus_handshake
  import port8_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic read,
  input wire logic write,
  output logic waitrequest,
  output logic sample,
  output logic take
);

  bus_state_t state_reg;
  bus_state_t state_next;
  logic req;

  // ==========================================================
  // state
  assign req = read | write;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      BUS_IDLE:
      begin
        if (req)
          state_next = BUS_ACK;
      end
      BUS_ACK:
        state_next = BUS_IDLE;
      default:
        state_next = BUS_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      state_reg <= BUS_IDLE;
    else
      state_reg <= state_next;
  end

  // ==========================================================
  // strobes: sample in the wait cycle, take in the answer cycle
  assign waitrequest = req & (state_reg == BUS_IDLE);
  assign sample = req & (state_reg == BUS_IDLE);
  assign take = req & (state_reg == BUS_ACK);

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  one_wait_a: assert property (waitrequest |=> !waitrequest)
    else $error("waitrequest held longer than one cycle");
  take_after_a: assert property (take |-> $past(sample))
    else $error("answer without a preceding wait cycle");

endmodule

// >>> core/pin_mux.sv
/*
  per-pin output selection: direction bit and latch, with the two
  timer compare outputs taking over their pins when enabled.
  assumes the timer signals are synchronous to the port clock.
*/
module pin_mux
  import port8_pkg::*;
#(
  parameter int WIDTH = PORT_W
)
(
  input wire logic [WIDTH-1:0] dir,
  input wire logic [WIDTH-1:0] latch,
  input wire logic compare_out_enable_a,
  input wire logic compare_out_enable_b,
  input wire logic timer_compare_out_a,
  input wire logic timer_compare_out_b,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe
);

  // ==========================================================
  // elaboration check: pin roles are fixed to an eight-bit port
  if (WIDTH != PORT_W)
  begin : g_bad_width
    $error("pin_mux needs WIDTH equal to PORT_W");
  end

  // ==========================================================
  // per-pin selection
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_pin
    if (i == PIN_CMP_A)
    begin : g_cmp_a
      assign pin_oe[i] = compare_out_enable_a | dir[i];
      assign pin_out[i] = compare_out_enable_a ? timer_compare_out_a : latch[i];
    end
    else if (i == PIN_CMP_B)
    begin : g_cmp_b
      assign pin_oe[i] = compare_out_enable_b | dir[i];
      assign pin_out[i] = compare_out_enable_b ? timer_compare_out_b : latch[i];
    end
    else
    begin : g_gp
      assign pin_oe[i] = dir[i];
      assign pin_out[i] = latch[i];
    end
  end

endmodule

// >>> core/io_port8.sv
/*
  eight-bit general-purpose io port with output latch and write-only
  direction register, reached over avalon-mm with waitrequest.
  assumes pins and timer signals are synchronous to mclk and that the
  surrounding pad logic resolves pin level from pin_out and pin_oe.
*/
// Local design decision: the Avalon-MM register port.
// Behaviour
// - the output latch holds eight writable output bits, bit 7 down to bit 0, read back only for pins whose direction bit is one.
// - a direction bit of one makes its pin an output, zero makes it an input.
// - a port read returns the latch bit for every pin whose direction bit is one.
// - a port read returns the sampled pin level for every pin whose direction bit is zero.
// - reset clears the output latch to zero.
// - reset clears the direction register, so all pins start as inputs except pins 1 and 2, which stay driven while their compare output is enabled.
// - the direction register cannot be read back: its address always reads all ones.
// - pin 7 is plain general purpose, governed by its direction bit only.
module io_port8
  import port8_pkg::*;
#(
  parameter int AW = port8_pkg::ADDR_W
)
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic [AW-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [port8_pkg::DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [port8_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,
  input wire logic [port8_pkg::PORT_W-1:0] pin_in,
  output logic [port8_pkg::PORT_W-1:0] pin_out,
  output logic [port8_pkg::PORT_W-1:0] pin_oe,
  input wire logic compare_out_enable_a,
  input wire logic compare_out_enable_b,
  input wire logic timer_compare_out_a,
  input wire logic timer_compare_out_b,
  output logic timer_capture_in_a,
  output logic timer_capture_in_b,
  output logic timer_capture_in_c,
  output logic timer_capture_in_d,
  output logic timer_count_clock_in
);

  import port8_pkg::*;

  // ==========================================================
  // elaboration check
  if (AW < ADDR_W)
  begin : g_bad_aw
    $error("io_port8 needs AW of at least ADDR_W");
  end

  // ==========================================================
  // declarations
  logic [PORT_W-1:0] port_output_latch_reg;
  logic [PORT_W-1:0] port_output_latch_next;
  logic [PORT_W-1:0] port_direction_reg;
  logic [PORT_W-1:0] port_direction_next;
  logic [DATA_W-1:0] readdata_reg;
  logic [DATA_W-1:0] readdata_next;
  logic [PORT_W-1:0] port_view;
  logic sample;
  logic take;
  logic hit_latch;
  logic hit_dir;
  logic wr_latch;
  logic wr_dir;

  // ==========================================================
  // bus handshake
  bus_handshake u_bus (
    .mclk(mclk),
    .srst(srst),
    .read(read),
    .write(write),
    .waitrequest(waitrequest),
    .sample(sample),
    .take(take)
  );

  // ==========================================================
  // address decode
  // upper address bits beyond ADDR_W must be zero, so aliases never hit
  assign hit_latch = (address == AW'(LATCH_ADDR));
  assign hit_dir = (address == AW'(DIR_ADDR));

  // only byte lane 0 carries register data; other lanes are ignored
  assign wr_latch = take & write & hit_latch & byteenable[0];
  assign wr_dir = take & write & hit_dir & byteenable[0];

  // ==========================================================
  // output latch
  always_comb
  begin
    port_output_latch_next = port_output_latch_reg;
    if (wr_latch)
      port_output_latch_next = writedata[PORT_W-1:0];
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      port_output_latch_reg <= LATCH_RST;
    else
      port_output_latch_reg <= port_output_latch_next;
  end

  // ==========================================================
  // direction register
  always_comb
  begin
    port_direction_next = port_direction_reg;
    if (wr_dir)
      port_direction_next = writedata[PORT_W-1:0];
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      port_direction_reg <= DIR_RST;
    else
      port_direction_reg <= port_direction_next;
  end

  // ==========================================================
  // read path
  // outputs read from the latch, so a loaded pin never corrupts read-modify-write
  assign port_view = (port_direction_reg & port_output_latch_reg)
                   | (~port_direction_reg & pin_in);

  always_comb
  begin
    readdata_next = readdata_reg;
    if (sample & read)
    begin
      if (hit_latch)
        readdata_next = {{(DATA_W-PORT_W){1'b0}}, port_view};
      else if (hit_dir)
        readdata_next = {{(DATA_W-PORT_W){1'b0}}, DIR_READ};
      else
        readdata_next = '0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      readdata_reg <= '0;
    else
      readdata_reg <= readdata_next;
  end

  assign readdata = readdata_reg;

  // ==========================================================
  // pin drivers
  pin_mux #(
    .WIDTH(PORT_W)
  ) u_mux (
    .dir(port_direction_reg),
    .latch(port_output_latch_reg),
    .compare_out_enable_a(compare_out_enable_a),
    .compare_out_enable_b(compare_out_enable_b),
    .timer_compare_out_a(timer_compare_out_a),
    .timer_compare_out_b(timer_compare_out_b),
    .pin_out(pin_out),
    .pin_oe(pin_oe)
  );

  // ==========================================================
  // timer feeds
  // the timer watches the pad even when the port drives it
  assign timer_capture_in_d = pin_in[PIN_CAP_D];
  assign timer_capture_in_c = pin_in[PIN_CAP_C];
  assign timer_capture_in_b = pin_in[PIN_CAP_B];
  assign timer_capture_in_a = pin_in[PIN_CAP_A];
  assign timer_count_clock_in = pin_in[PIN_CNT_CLK];

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  latch_write_a: assert property (
    wr_latch |=> port_output_latch_reg == $past(writedata[PORT_W-1:0])
  ) else $error("latch did not take written byte");

  dir_out_a: assert property (
    !compare_out_enable_a && !compare_out_enable_b |-> pin_oe == port_direction_reg
  ) else $error("pin enable does not follow direction");

  read_output_a: assert property (
    sample && read && hit_latch |=>
      (readdata[PORT_W-1:0] & $past(port_direction_reg))
        == ($past(port_output_latch_reg) & $past(port_direction_reg))
  ) else $error("output pin read not from latch");

  read_input_a: assert property (
    sample && read && hit_latch |=>
      (readdata[PORT_W-1:0] & ~$past(port_direction_reg))
        == ($past(pin_in) & ~$past(port_direction_reg))
  ) else $error("input pin read not from pad");

  latch_reset_a: assert property (
    @(posedge mclk) $fell(srst) |-> port_output_latch_reg == LATCH_RST
  ) else $error("latch not cleared by reset");

  dir_reset_a: assert property (
    @(posedge mclk) $fell(srst) |-> port_direction_reg == DIR_RST && readdata == '0
  ) else $error("direction not cleared by reset");

  dir_ones_a: assert property (
    sample && read && hit_dir |=> readdata == {{(DATA_W-PORT_W){1'b0}}, DIR_READ}
  ) else $error("direction read not all ones");

  pin7_plain_a: assert property (
    pin_oe[PIN_GP] == port_direction_reg[PIN_GP]
      && pin_out[PIN_GP] == port_output_latch_reg[PIN_GP]
  ) else $error("pin 7 not plain general purpose");

  timer_feed_a: assert property (
    {timer_capture_in_d, timer_capture_in_c, timer_capture_in_b, timer_capture_in_a}
      == pin_in[PIN_CAP_D:PIN_CAP_A] && timer_count_clock_in == pin_in[PIN_CNT_CLK]
  ) else $error("timer inputs not fed from pins");

  cmp_a_take_a: assert property (
    compare_out_enable_a |-> pin_oe[PIN_CMP_A] && pin_out[PIN_CMP_A] == timer_compare_out_a
  ) else $error("compare a does not own pin 1");

  cmp_b_take_a: assert property (
    compare_out_enable_b |-> pin_oe[PIN_CMP_B] && pin_out[PIN_CMP_B] == timer_compare_out_b
  ) else $error("compare b does not own pin 2");

  gp_drive_a: assert property (
    wr_latch && port_direction_reg[PIN_GP] |=> pin_out[PIN_GP] == $past(writedata[PIN_GP])
      && pin_oe[PIN_GP]
  ) else $error("written level not on output pin");

  answer_time_a: assert property (
    (read || write) && waitrequest |=> !waitrequest
  ) else $error("slave answer later than one wait cycle");

  // ==========================================================
  // stand-still and refusal checks
  // registers move only on a landed write; a refused write leaves both alone
  take_ready_a: assert property (
    take |-> !waitrequest
  ) else $error("answer cycle still waiting");

  latch_hold_a: assert property (
    !wr_latch |=> port_output_latch_reg == $past(port_output_latch_reg)
  ) else $error("latch moved without a write");

  refuse_be_a: assert property (
    take && write && !byteenable[0] |=> $stable(port_output_latch_reg) && $stable(port_direction_reg)
  ) else $error("write without lane 0 changed a register");

  refuse_addr_a: assert property (
    take && write && !hit_latch && !hit_dir |=> $stable(port_output_latch_reg) && $stable(port_direction_reg)
  ) else $error("unmapped write changed a register");

  dir_write_a: assert property (
    wr_dir |=> port_direction_reg == $past(writedata[PORT_W-1:0])
  ) else $error("direction did not take written byte");

  dir_hold_a: assert property (
    !wr_dir |=> $stable(port_direction_reg)
  ) else $error("direction moved without a write");

  oe_reset_a: assert property (
    $fell(srst) |-> (pin_oe & 8'hf9) == 8'h00
  ) else $error("pins driven after reset");

  unmapped_zero_a: assert property (
    sample && read && !hit_latch && !hit_dir |=> readdata == '0
  ) else $error("unmapped read not zero");

  readdata_hold_a: assert property (
    !(sample && read) |=> $stable(readdata)
  ) else $error("read data changed outside a read");

  upper_zero_a: assert property (
    readdata[DATA_W-1:PORT_W] == '0
  ) else $error("read data upper bytes not zero");

  gp_pins_a: assert property (
    pin_out[PIN_GP:PIN_CAP_A] == port_output_latch_reg[PIN_GP:PIN_CAP_A]
      && pin_out[PIN_CNT_CLK] == port_output_latch_reg[PIN_CNT_CLK]
  ) else $error("plain pin not driven from latch");

  cmp_a_off_a: assert property (
    !compare_out_enable_a |-> pin_oe[PIN_CMP_A] == port_direction_reg[PIN_CMP_A]
      && pin_out[PIN_CMP_A] == port_output_latch_reg[PIN_CMP_A]
  ) else $error("pin 1 not plain while compare a off");

  cmp_b_off_a: assert property (
    !compare_out_enable_b |-> pin_oe[PIN_CMP_B] == port_direction_reg[PIN_CMP_B]
      && pin_out[PIN_CMP_B] == port_output_latch_reg[PIN_CMP_B]
  ) else $error("pin 2 not plain while compare b off");

  cov_read_port: cover property (sample && read && hit_latch);
  cov_write_dir: cover property (wr_dir);
  cov_read_dir: cover property (sample && read && hit_dir);
  cov_cmp_over: cover property (compare_out_enable_a && !port_direction_reg[PIN_CMP_A]);
  cov_gp_write: cover property (wr_latch && port_direction_reg[PIN_GP]);

endmodule

// >>> test/board_model.sv
/*
  board and timer model for the eight-bit io port: resolves pin levels
  and supplies the timer compare enables and levels.
  assumes the bench sets ext_level, fight and the compare controls.
*/
module board_model
  import port8_pkg::*;
(
  input wire logic [PORT_W-1:0] pin_out,
  input wire logic [PORT_W-1:0] pin_oe,
  input wire logic [PORT_W-1:0] ext_level,
  input wire logic fight,
  input wire logic [1:0] cmp_en,
  input wire logic [1:0] cmp_lvl,
  output logic [PORT_W-1:0] pin_in,
  output logic compare_out_enable_a,
  output logic compare_out_enable_b,
  output logic timer_compare_out_a,
  output logic timer_compare_out_b
);
  // ==========================================================
  // pads: a driven pin reads its own level unless the board overpowers it
  always_comb
  begin
    for (int i = 0; i < PORT_W; i++)
    begin
      pin_in[i] = (pin_oe[i] && !fight) ? pin_out[i] : ext_level[i];
    end
  end
  // ==========================================================
  // timer side
  assign compare_out_enable_a = cmp_en[0];
  assign compare_out_enable_b = cmp_en[1];
  assign timer_compare_out_a = cmp_lvl[0];
  assign timer_compare_out_b = cmp_lvl[1];
endmodule

// >>> test/tb_top.sv
/*
  self-checking bench for the eight-bit io port.
  assumes the one-wait-cycle avalon handshake of the port.
*/
module tb_top;
  import port8_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0, srst = 1'b1, read = 1'b0, write = 1'b0, fight = 1'b0, wr_q;
  logic [ADDR_W-1:0] address = '0;
  logic [31:0] writedata = '0, readdata, q;
  logic [3:0] byteenable = 4'h1;
  logic waitrequest, cea, ceb, tca, tcb, ci_a, ci_b, ci_c, ci_d, cclk;
  logic [7:0] pin_in, pin_out, pin_oe, ext_level = 8'h00;
  logic [1:0] cmp_en = 2'b00, cmp_lvl = 2'b00;
  int fail_count = 0, checks = 0, cyc = 0;

  io_port8 i_dut (.mclk(mclk), .srst(srst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .compare_out_enable_a(cea),
    .compare_out_enable_b(ceb), .timer_compare_out_a(tca), .timer_compare_out_b(tcb),
    .timer_capture_in_a(ci_a), .timer_capture_in_b(ci_b), .timer_capture_in_c(ci_c),
    .timer_capture_in_d(ci_d), .timer_count_clock_in(cclk));
  board_model i_board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level), .fight(fight),
    .cmp_en(cmp_en), .cmp_lvl(cmp_lvl), .pin_in(pin_in), .compare_out_enable_a(cea),
    .compare_out_enable_b(ceb), .timer_compare_out_a(tca), .timer_compare_out_b(tcb));

  initial
  begin
    forever #20 mclk = ~mclk;
  end
  // waitrequest seen mid-cycle equals what the next rising edge samples
  always @(negedge mclk) wr_q = waitrequest;
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      fail_count++;
      end_of_test();
    end
  end

  // ==========================================================
  // helpers
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d,
    input logic [3:0] be);
    @(posedge mclk);
    address <= a;
    writedata <= {24'h0, d};
    byteenable <= be;
    read <= !wr;
    write <= wr;
    do @(posedge mclk); while (wr_q !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic pins(input logic [7:0] oe, input logic [7:0] out);
    @(negedge mclk);
    check(pin_oe, oe);
    check(pin_out & oe, out & oe);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_inputs();
    logic [7:0] lvl;
    for (int i = 0; i < 2; i++)
    begin
      lvl = i ? 8'h5a : 8'ha5;
      ext_level <= lvl;
      xfer(1'b0, LATCH_ADDR, 8'h00, 4'h1);
      check(q, {24'h0, lvl});
      check({ci_d, ci_c, ci_b, ci_a, cclk}, {lvl[6:3], lvl[0]});
    end
    $display("inputs done");
  endtask

  task automatic t_outputs();
    xfer(1'b1, LATCH_ADDR, 8'h3c, 4'h1);
    xfer(1'b1, DIR_ADDR, 8'hff, 4'h1);
    pins(8'hff, 8'h3c);
    @(posedge mclk);
    fight <= 1'b1;
    ext_level <= 8'hc3;
    xfer(1'b0, LATCH_ADDR, 8'h00, 4'h1);
    check(q, 32'h3c);
    check({ci_d, ci_c, ci_b, ci_a, cclk}, {4'h8, 1'b1});
    xfer(1'b1, DIR_ADDR, 8'h0f, 4'h1);
    xfer(1'b0, LATCH_ADDR, 8'h00, 4'h1);
    check(q, 32'hcc);
    $display("outputs done");
  endtask

  task automatic t_refuse();
    xfer(1'b1, 18'h0, 8'hff, 4'h1);
    xfer(1'b1, LATCH_ADDR, 8'hff, 4'h0);
    xfer(1'b1, DIR_ADDR, 8'hff, 4'h1);
    xfer(1'b0, LATCH_ADDR, 8'h00, 4'h1);
    check(q, 32'h3c);
    xfer(1'b0, 18'h0, 8'h00, 4'h1);
    check(q, 32'h0);
    xfer(1'b0, DIR_ADDR, 8'h00, 4'h1);
    check(q, 32'hff);
    $display("refuse done");
  endtask

  task automatic t_compare();
    logic [7:0] oe, out;
    for (int d = 0; d < 2; d++)
    begin
      xfer(1'b1, DIR_ADDR, d ? 8'h81 : 8'h00, 4'h1);
      for (int i = 0; i < 4; i++)
      begin
        @(posedge mclk);
        cmp_en <= i[1:0];
        cmp_lvl <= ~i[1:0];
        oe = (d ? 8'h81 : 8'h00) | {5'h0, i[1:0], 1'b0};
        out = {8'h3c & 8'hf9} | {5'h0, ~i[1:0], 1'b0};
        pins(oe, out);
      end
    end
    @(posedge mclk);
    cmp_en <= 2'b00;
    $display("compare done");
  endtask

  task automatic t_reset();
    @(posedge mclk);
    srst <= 1'b1;
    ext_level <= 8'h96;
    @(posedge mclk);
    srst <= 1'b0;
    pins(8'h00, 8'h00);
    xfer(1'b0, LATCH_ADDR, 8'h00, 4'h1);
    check(q, 32'h96);
    xfer(1'b1, DIR_ADDR, 8'hff, 4'h1);
    xfer(1'b0, LATCH_ADDR, 8'h00, 4'h1);
    check(q, 32'h00);
    xfer(1'b1, LATCH_ADDR, 8'h80, 4'h1);
    pins(8'hff, 8'h80);
    xfer(1'b0, LATCH_ADDR, 8'h00, 4'h1);
    check(q, 32'h80);
    $display("reset done");
  endtask

  initial
  begin
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    pins(8'h00, 8'h00);
    xfer(1'b0, DIR_ADDR, 8'h00, 4'h1);
    check(q, 32'hff);
    t_inputs();
    t_outputs();
    t_refuse();
    t_compare();
    t_reset();
    end_of_test();
  end
endmodule
